/* File: rtl/dos_pkg.sv */
`default_nettype none
package dos_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_PULSE_TYPE  = 8'h00;
  localparam logic [7:0]  OFS_CODING      = 8'h04;
  localparam logic [7:0]  OFS_MON_FUNC    = 8'h08;
  localparam logic [7:0]  OFS_BRAKE_MODE  = 8'h0C;
  localparam logic [7:0]  OFS_BRAKE_TH    = 8'h10;
  localparam logic [7:0]  OFS_TEST_SPEED  = 8'h14;
  localparam logic [7:0]  OFS_STATUS      = 8'h18;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0]  PT_PP_A         = 2'h0;
  localparam logic [1:0]  PT_QUAD_AB      = 2'h1;
  localparam logic [1:0]  PT_PP_B         = 2'h2;
  localparam logic [1:0]  PT_QUAD_BA      = 2'h3;
  localparam logic [3:0]  FN_INCR         = 4'h0;
  localparam logic [3:0]  FN_DISP1        = 4'h1;
  localparam logic [3:0]  FN_DISP2        = 4'h2;
  localparam logic [3:0]  FN_ABS          = 4'h3;
  localparam logic [3:0]  DS_SPEED        = 4'h0;
  localparam logic [3:0]  DS_POS          = 4'h1;
  localparam logic [3:0]  DS_CURRENT      = 4'h2;
  localparam logic [3:0]  DS_TEMP         = 4'h3;
  localparam logic [3:0]  DS_MARKER       = 4'h4;
  localparam logic [3:0]  DS_MACH_SPEED   = 4'h5;
  localparam logic [3:0]  AF_32           = 4'h0;
  localparam logic [3:0]  AF_23P          = 4'h1;
  localparam logic [3:0]  AF_24P          = 4'h2;
  localparam logic [3:0]  AF_31P          = 4'h3;
  localparam logic [5:0]  LEN_DISP1       = 6'h10;
  localparam logic [5:0]  LEN_32          = 6'h20;
  localparam logic [5:0]  LEN_23P         = 6'h18;
  localparam logic [5:0]  LEN_24P         = 6'h19;

  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [11:0] TEST_SPEED_MIN  = 12'h001;
  localparam logic [11:0] TEST_SPEED_MAX  = 12'hFA0;
  localparam logic [9:0]  BRAKE_TH_MAX    = 10'h3E8;

  // ---------------------------------------------------------------
  // timing: serial bit phase of 1000 ns at a 40 ns clock
  // ---------------------------------------------------------------
  localparam int          CLK_NS          = 40;
  localparam int          SER_PHASE_NS    = 1000;
  localparam int          SER_DIV_CYC     = SER_PHASE_NS / CLK_NS;
  localparam logic [5:0]  SER_GAP_PHASES  = 6'h10;

  typedef struct packed {
    logic [1:0]  pulse_type;
    logic [15:0] coding;
    logic [2:0]  mon_func;
    logic [1:0]  brake_mode;
    logic [9:0]  brake_th;
    logic [11:0] test_speed;
  } dos_cfg_s;

  localparam dos_cfg_s CFG_RST = '{pulse_type: 2'h1, coding: 16'h0000, mon_func: 3'h2,
                                   brake_mode: 2'h0, brake_th: 10'h3E8,
                                   test_speed: 12'h032};

  typedef struct packed {
    logic a;
    logic b;
  } dos_pulse_s;

  typedef struct packed {
    logic [3:0] disp_sel;
    logic [1:0] act_mode;
    logic       mon_sel;
    logic       brake;
  } dos_status_s;

  typedef enum logic [3:0] {
    SER_LOAD  = 4'h1,
    SER_SETUP = 4'h2,
    SER_CLOCK = 4'h4,
    SER_GAP   = 4'h8
  } dos_ser_e;
endpackage
`default_nettype wire

/* File: rtl/dos_quad_enc.sv */
`default_nettype none
module dos_quad_enc (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              step_in,
  input  wire logic              inc_in,
  input  wire logic [1:0]        type_in,
  output var dos_pkg::dos_pulse_s pulse_out
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  wire        ga = next_cnt[1] ^ next_cnt[0];
  wire        gb = next_cnt[1];

  assign next_cnt = !step_in ? cnt : (inc_in ? cnt + 2'h1 : cnt - 2'h1);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt       <= 2'h0;
      pulse_out <= '0;
    end else begin
      cnt <= next_cnt;
      case (type_in)
        dos_pkg::PT_QUAD_AB: pulse_out <= '{a: ga, b: gb};
        dos_pkg::PT_QUAD_BA: pulse_out <= '{a: gb, b: ga};
        dos_pkg::PT_PP_A:    pulse_out <= '{a: step_in & inc_in, b: step_in & !inc_in};
        dos_pkg::PT_PP_B:    pulse_out <= '{a: step_in & !inc_in, b: step_in & inc_in};
        default:             pulse_out <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dos_ser.sv */
`default_nettype none
module dos_ser (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              tick_in,
  input  wire logic              run_in,
  input  wire logic [31:0]       word_in,
  input  wire logic [5:0]        len_in,
  output var dos_pkg::dos_pulse_s pulse_out
);
  // a carries data msb first, b is the bit clock; receiver samples on b rising
  dos_pkg::dos_ser_e state;
  logic [31:0]       sh;
  logic [5:0]        left;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state     <= dos_pkg::SER_LOAD;
      sh        <= '0;
      left      <= '0;
      pulse_out <= '{a: 1'b0, b: 1'b1};
    end else if (!run_in) begin
      state     <= dos_pkg::SER_LOAD;
      pulse_out <= '{a: 1'b0, b: 1'b1};
    end else if (tick_in) begin
      case (state)
        dos_pkg::SER_LOAD: begin
          sh    <= word_in << (6'h20 - len_in);
          left  <= len_in;
          state <= dos_pkg::SER_SETUP;
        end
        dos_pkg::SER_SETUP: begin
          pulse_out <= '{a: sh[31], b: 1'b0};
          sh        <= {sh[30:0], 1'b0};
          left      <= left - 6'h1;
          state     <= dos_pkg::SER_CLOCK;
        end
        dos_pkg::SER_CLOCK: begin
          pulse_out.b <= 1'b1;
          if (left == 6'h0) begin
            left  <= dos_pkg::SER_GAP_PHASES;
            state <= dos_pkg::SER_GAP;
          end else begin
            state <= dos_pkg::SER_SETUP;
          end
        end
        dos_pkg::SER_GAP: begin
          pulse_out.a <= 1'b0;
          left        <= left - 6'h1;
          if (left == 6'h1) begin
            state <= dos_pkg::SER_LOAD;
          end
        end
        default: state <= dos_pkg::SER_LOAD;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dos_top.sv */
// Contract
// - code 11 gives quadrature, B leads A
// - 01 A leads; 00/10 pulse-per-direction
// - monitor-select off: first digit picks display
// - monitor-select on: second digit picks display
// - third digit picks absolute word format
// - format digit used only for absolute function
// - fourth digit picks pulse output function
// - select on: first monitor digit torque/speed
// - select off: second monitor digit torque/speed
// - third monitor digit inverts monitor
// - modes 1,2 brake below speed threshold
// - mode 0 ignores brake threshold
// - mode acts on disable; alarm brakes
// - jog runs at test speed 1..4000
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`default_nettype none
module dos_top #(
  parameter int SER_DIV = dos_pkg::SER_DIV_CYC
) (
  input  wire logic        CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        MON_SEL_IN,
  input  wire logic        POS_STEP_IN,
  input  wire logic        POS_INC_IN,
  input  wire logic [31:0] ABS_POS_IN,
  input  wire logic [15:0] MOTOR_RPM_IN,
  input  wire logic [15:0] CURRENT_IN,
  input  wire logic [15:0] TEMP_IN,
  input  wire logic [15:0] MARKER_DIST_IN,
  input  wire logic [15:0] MACHINE_RPM_IN,
  input  wire logic [15:0] TORQUE_MON_IN,
  input  wire logic [15:0] SPEED_MON_IN,
  input  wire logic [9:0]  SPEED_PERMIL_IN,
  input  wire logic        DRIVE_EN_IN,
  input  wire logic        ALARM_IN,
  input  wire logic        JOG_REQ_IN,
  output logic             PULSE_OUT_A_OUT,
  output logic             PULSE_OUT_B_OUT,
  output logic [3:0]       DISP_SEL_OUT,
  output logic [31:0]      DISP_VALUE_OUT,
  output logic [15:0]      ANALOG_MONITOR_POINT_OUT,
  output logic             BRAKE_OUT,
  output logic [11:0]      JOG_SPEED_OUT
);
  generate
    if (SER_DIV < 2 || SER_DIV > 65536) begin : g_bad_div
      $error("SER_DIV must lie between 2 and 65536");
    end
  endgenerate

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  dos_pkg::dos_cfg_s    cfg;
  dos_pkg::dos_cfg_s    next_cfg;
  dos_pkg::dos_status_s status;
  logic                 wr_pend;
  logic [7:0]           wr_addr;
  logic [1:0]           act_mode;
  logic                 mon_meta;
  logic                 mon_sync;
  logic                 brake;

  wire        acc      = HSEL_IN & HREADY_IN & HTRANS_IN[1];
  wire        hi_zero  = HADDR_IN[31:8] == 24'h000000;
  wire [7:0]  ra       = HADDR_IN[7:0];
  wire        wr_ok    = acc & HWRITE_IN & hi_zero & (HSIZE_IN == dos_pkg::HSIZE_WORD);
  wire        w_type   = wr_pend && wr_addr == dos_pkg::OFS_PULSE_TYPE;
  wire        w_coding = wr_pend && wr_addr == dos_pkg::OFS_CODING;
  wire        w_mon    = wr_pend && wr_addr == dos_pkg::OFS_MON_FUNC;
  wire        w_bmode  = wr_pend && wr_addr == dos_pkg::OFS_BRAKE_MODE;
  wire        w_bth    = wr_pend && wr_addr == dos_pkg::OFS_BRAKE_TH;
  wire        w_speed  = wr_pend && wr_addr == dos_pkg::OFS_TEST_SPEED;
  wire [11:0] wd_speed = HWDATA_IN[11:0];
  wire [9:0]  wd_bth   = HWDATA_IN[9:0];
  wire        spd_big  = HWDATA_IN[31:12] != 20'h00000 || wd_speed > dos_pkg::TEST_SPEED_MAX;
  wire        bth_big  = HWDATA_IN[31:10] != 22'h000000 || wd_bth > dos_pkg::BRAKE_TH_MAX;

  // out-of-range writes saturate so the jog and brake logic never see a bad value
  wire [11:0] speed_sat = spd_big ? dos_pkg::TEST_SPEED_MAX :
                          (wd_speed < dos_pkg::TEST_SPEED_MIN) ? dos_pkg::TEST_SPEED_MIN :
                          wd_speed;
  wire [9:0]  bth_sat   = bth_big ? dos_pkg::BRAKE_TH_MAX : wd_bth;

  always_comb begin
    next_cfg = cfg;
    if (w_type) next_cfg.pulse_type = HWDATA_IN[1:0];
    if (w_coding) next_cfg.coding = HWDATA_IN[15:0];
    if (w_mon) next_cfg.mon_func = HWDATA_IN[2:0];
    if (w_bmode) next_cfg.brake_mode = HWDATA_IN[1:0];
    if (w_bth) next_cfg.brake_th = bth_sat;
    if (w_speed) next_cfg.test_speed = speed_sat;
  end

  assign status = '{disp_sel: DISP_SEL_OUT, act_mode: act_mode, mon_sel: mon_sync, brake: brake};

  wire [31:0] rd_data =
    !hi_zero                         ? 32'h00000000 :
    ra == dos_pkg::OFS_PULSE_TYPE    ? {30'h00000000, cfg.pulse_type} :
    ra == dos_pkg::OFS_CODING        ? {16'h0000, cfg.coding} :
    ra == dos_pkg::OFS_MON_FUNC      ? {29'h00000000, cfg.mon_func} :
    ra == dos_pkg::OFS_BRAKE_MODE    ? {30'h00000000, cfg.brake_mode} :
    ra == dos_pkg::OFS_BRAKE_TH      ? {22'h000000, cfg.brake_th} :
    ra == dos_pkg::OFS_TEST_SPEED    ? {20'h00000, cfg.test_speed} :
    ra == dos_pkg::OFS_STATUS        ? {24'h000000, status} : 32'h00000000;

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cfg           <= dos_pkg::CFG_RST;
      wr_pend       <= 1'b0;
      wr_addr       <= 8'h00;
      HRDATA_OUT    <= 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      cfg     <= next_cfg;
      wr_pend <= wr_ok;
      if (wr_ok) wr_addr <= ra;
      if (acc && !HWRITE_IN) HRDATA_OUT <= rd_data;
    end
  end

  // ---------------------------------------------------------------
  // monitor select synchroniser and display selection
  // ---------------------------------------------------------------
  wire [3:0] dig1    = cfg.coding[15:12];
  wire [3:0] dig2    = cfg.coding[11:8];
  wire [3:0] dig_fmt = cfg.coding[7:4];
  wire [3:0] dig_fn  = cfg.coding[3:0];
  wire [3:0] disp_d  = mon_sync ? dig2 : dig1;

  wire [31:0] disp_v =
    disp_d == dos_pkg::DS_POS        ? ABS_POS_IN :
    disp_d == dos_pkg::DS_CURRENT    ? {16'h0000, CURRENT_IN} :
    disp_d == dos_pkg::DS_TEMP       ? {16'h0000, TEMP_IN} :
    disp_d == dos_pkg::DS_MARKER     ? {16'h0000, MARKER_DIST_IN} :
    disp_d == dos_pkg::DS_MACH_SPEED ? {{16{MACHINE_RPM_IN[15]}}, MACHINE_RPM_IN} :
                                       {{16{MOTOR_RPM_IN[15]}}, MOTOR_RPM_IN};

  wire        mon_spd = mon_sync ? cfg.mon_func[2] : cfg.mon_func[1];
  wire [15:0] mon_src = mon_spd ? SPEED_MON_IN : TORQUE_MON_IN;
  wire [15:0] mon_v   = cfg.mon_func[0] ? 16'h0000 - mon_src : mon_src;

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mon_meta                 <= 1'b0;
      mon_sync                 <= 1'b0;
      DISP_SEL_OUT             <= 4'h0;
      DISP_VALUE_OUT           <= 32'h00000000;
      ANALOG_MONITOR_POINT_OUT <= 16'h0000;
    end else begin
      mon_meta                 <= MON_SEL_IN;
      mon_sync                 <= mon_meta;
      DISP_SEL_OUT             <= disp_d;
      DISP_VALUE_OUT           <= disp_v;
      ANALOG_MONITOR_POINT_OUT <= mon_v;
    end
  end

  // ---------------------------------------------------------------
  // pulse outputs
  // ---------------------------------------------------------------
  dos_pkg::dos_pulse_s enc_p;
  dos_pkg::dos_pulse_s ser_p;
  logic [15:0]         div_cnt;
  logic                tick;
  logic [31:0]         ser_word;
  logic [5:0]          ser_len;

  wire is_incr = dig_fn == dos_pkg::FN_INCR;
  wire is_abs  = dig_fn == dos_pkg::FN_ABS;
  wire is_disp = dig_fn == dos_pkg::FN_DISP1 || dig_fn == dos_pkg::FN_DISP2;
  wire par23   = ^ABS_POS_IN[22:0];
  wire par24   = ^ABS_POS_IN[23:0];
  wire par31   = ^ABS_POS_IN[30:0];

  // format digit only matters for the absolute function
  always_comb begin
    ser_word = DISP_VALUE_OUT;
    ser_len  = dos_pkg::LEN_32;
    if (dig_fn == dos_pkg::FN_DISP1) begin
      ser_word = {16'h0000, DISP_VALUE_OUT[15:0]};
      ser_len  = dos_pkg::LEN_DISP1;
    end else if (is_abs) begin
      case (dig_fmt)
        dos_pkg::AF_23P: begin
          ser_word = {8'h00, ABS_POS_IN[22:0], par23};
          ser_len  = dos_pkg::LEN_23P;
        end
        dos_pkg::AF_24P: begin
          ser_word = {7'h00, ABS_POS_IN[23:0], par24};
          ser_len  = dos_pkg::LEN_24P;
        end
        dos_pkg::AF_31P: ser_word = {ABS_POS_IN[30:0], par31};
        default:         ser_word = ABS_POS_IN;
      endcase
    end
  end

  dos_quad_enc u_enc (
    .clk_in    (CLK_IN),
    .nrst_in   (NRST_IN),
    .step_in   (POS_STEP_IN),
    .inc_in    (POS_INC_IN),
    .type_in   (cfg.pulse_type),
    .pulse_out (enc_p)
  );

  dos_ser u_ser (
    .clk_in    (CLK_IN),
    .nrst_in   (NRST_IN),
    .tick_in   (tick),
    .run_in    (is_abs | is_disp),
    .word_in   (ser_word),
    .len_in    (ser_len),
    .pulse_out (ser_p)
  );

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      div_cnt         <= 16'h0000;
      tick            <= 1'b0;
      PULSE_OUT_A_OUT <= 1'b0;
      PULSE_OUT_B_OUT <= 1'b0;
    end else begin
      tick    <= div_cnt == 16'(SER_DIV - 1);
      div_cnt <= (div_cnt == 16'(SER_DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
      PULSE_OUT_A_OUT <= is_incr ? enc_p.a : (is_abs | is_disp) & ser_p.a;
      PULSE_OUT_B_OUT <= is_incr ? enc_p.b : (is_abs | is_disp) & ser_p.b;
    end
  end

  // ---------------------------------------------------------------
  // holding brake and jog
  // ---------------------------------------------------------------
  wire below_th = SPEED_PERMIL_IN < cfg.brake_th;

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      act_mode      <= 2'h0;
      brake         <= 1'b1;
      BRAKE_OUT     <= 1'b1;
      JOG_SPEED_OUT <= 12'h000;
    end else begin
      if (DRIVE_EN_IN) act_mode <= cfg.brake_mode;
      if (ALARM_IN) begin
        brake <= 1'b1;
      end else if (DRIVE_EN_IN) begin
        brake <= 1'b0;
      end else if (act_mode != 2'h0 && below_th) begin
        brake <= 1'b1;
      end
      BRAKE_OUT     <= brake | ALARM_IN;
      JOG_SPEED_OUT <= JOG_REQ_IN ? cfg.test_speed : 12'h000;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  chk_quad_b_lead: assert property (
    is_incr && cfg.pulse_type == dos_pkg::PT_QUAD_BA && POS_STEP_IN && POS_INC_IN
    && !enc_p.a && !enc_p.b ##1 is_incr |-> ##1 PULSE_OUT_B_OUT && !PULSE_OUT_A_OUT)
    else $error("B did not lead A");
  chk_quad_a_lead: assert property (
    is_incr && cfg.pulse_type == dos_pkg::PT_QUAD_AB && POS_STEP_IN && POS_INC_IN
    && !enc_p.a && !enc_p.b ##1 is_incr |-> ##1 PULSE_OUT_A_OUT && !PULSE_OUT_B_OUT)
    else $error("A did not lead B");
  chk_disp_sel_off: assert property (!mon_sync ##1 !mon_sync |-> DISP_SEL_OUT == $past(dig1))
    else $error("display select off mismatch");
  chk_disp_sel_on: assert property (mon_sync ##1 mon_sync |-> DISP_SEL_OUT == $past(dig2))
    else $error("display select on mismatch");
  chk_abs_fmt_len: assert property (
    is_abs && dig_fmt == dos_pkg::AF_24P |-> ser_len == 6'h19)
    else $error("absolute length wrong");
  chk_fmt_ignored: assert property (dig_fn == dos_pkg::FN_DISP1 |-> ser_len == 6'h10)
    else $error("format digit leaked");
  chk_mon_on_sel: assert property (
    mon_sync && !cfg.mon_func[0] && cfg.mon_func[2]
    |=> ANALOG_MONITOR_POINT_OUT == $past(SPEED_MON_IN))
    else $error("monitor select on wrong");
  chk_mon_off_sel: assert property (
    !mon_sync && !cfg.mon_func[0] && !cfg.mon_func[1]
    |=> ANALOG_MONITOR_POINT_OUT == $past(TORQUE_MON_IN))
    else $error("monitor select off wrong");
  chk_mon_invert: assert property (
    cfg.mon_func[0] && !mon_spd |=> ANALOG_MONITOR_POINT_OUT == 16'h0000 - $past(TORQUE_MON_IN))
    else $error("monitor polarity wrong");
  chk_brake_thresh: assert property (
    !DRIVE_EN_IN && !ALARM_IN && act_mode != 2'h0 && below_th |-> ##2 BRAKE_OUT)
    else $error("brake not applied below threshold");
  chk_brake_mode0: assert property (
    !brake && act_mode == 2'h0 && !ALARM_IN && !DRIVE_EN_IN |=> !brake)
    else $error("mode 0 applied brake");
  chk_brake_alarm: assert property (ALARM_IN |=> BRAKE_OUT [*2])
    else $error("alarm did not brake");
  chk_jog_range: assert property (
    JOG_REQ_IN |=> JOG_SPEED_OUT >= 12'h001 && JOG_SPEED_OUT <= 12'hFA0)
    else $error("jog speed out of range");
  chk_sync_delay: assert property (
    $rose(MON_SEL_IN) ##1 MON_SEL_IN |=> mon_sync ##1 DISP_SEL_OUT == $past(dig2))
    else $error("select not taken in time");
endmodule
`default_nettype wire

/* File: dv/dos_rx_model.sv */
`default_nettype none
module dos_rx_model #(
  parameter int GAP_CYC = 8
) (
  input  wire logic   clk_in,
  input  wire logic   clr_in,
  input  wire logic   a_in,
  input  wire logic   b_in,
  output var int      quad_pos,
  output var int      rise_a,
  output var int      rise_b,
  output logic [31:0] last_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]  prev = 2'h0;
  logic [31:0] shift = 32'h0;
  int          hi_cnt = 0;
  int          d;
  function automatic int idx(input logic [1:0] s);
    return (s == 2'h0) ? 0 : (s == 2'h2) ? 1 : (s == 2'h3) ? 2 : 3;
  endfunction
  initial begin
    quad_pos = 0;
    rise_a = 0;
    rise_b = 0;
    last_word = 32'h0;
  end
  // every edge of either channel is one step, direction from the gray order
  always @(posedge clk_in) begin
    d = (idx({a_in, b_in}) - idx(prev)) & 3;
    if (clr_in) begin
      quad_pos = 0;
      rise_a = 0;
      rise_b = 0;
    end else begin
      quad_pos += (d == 1) ? 1 : (d == 3) ? -1 : 0;
      rise_a += (a_in && !prev[1]) ? 1 : 0;
      rise_b += (b_in && !prev[0]) ? 1 : 0;
    end
    // data is taken on the clock rise; a long high clock marks the word end
    if (b_in && !prev[0])
      shift = {shift[30:0], a_in};
    hi_cnt = b_in ? hi_cnt + 1 : 0;
    if (hi_cnt == GAP_CYC)
      last_word = shift;
    prev = {a_in, b_in};
  end
endmodule
`default_nettype wire

/* File: dv/drive_output_selection_tb.sv */
`default_nettype none
module drive_output_selection_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, hsel, hwrite, mon_sel, step, inc, en, alarm, jog, clr;
  logic        hready, hresp, pa, pb, brake;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  disp_sel;
  logic [9:0]  spd;
  logic [11:0] jog_speed;
  logic [15:0] mon_out, mv;
  logic [15:0] src [0:6];
  logic [31:0] haddr, hwdata, hrdata, abs_pos, disp_value, rd, rnd, word, ex, mk;
  logic [7:0]  ra_tab [0:7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
  logic [31:0] rv_tab [0:7] = '{32'h1, 32'h0, 32'h2, 32'h0, 32'h3E8, 32'h32, 32'h1, 32'h0};
  logic [11:0] js_tab [0:3] = '{12'hFA0, 12'hFA1, 12'h000, 12'h001};
  logic [11:0] je_tab [0:3] = '{12'hFA0, 12'hFA0, 12'h001, 12'h001};
  int          errors, total_checks, qpos, na, nb, ni, nd, n;
  dos_top #(.SER_DIV(2)) dos_top_inst (
    .CLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .MON_SEL_IN(mon_sel),
    .POS_STEP_IN(step), .POS_INC_IN(inc), .ABS_POS_IN(abs_pos), .MOTOR_RPM_IN(src[0]),
    .CURRENT_IN(src[1]), .TEMP_IN(src[2]), .MARKER_DIST_IN(src[3]), .MACHINE_RPM_IN(src[4]),
    .TORQUE_MON_IN(src[5]), .SPEED_MON_IN(src[6]), .SPEED_PERMIL_IN(spd),
    .DRIVE_EN_IN(en), .ALARM_IN(alarm), .JOG_REQ_IN(jog), .PULSE_OUT_A_OUT(pa),
    .PULSE_OUT_B_OUT(pb), .DISP_SEL_OUT(disp_sel), .DISP_VALUE_OUT(disp_value),
    .ANALOG_MONITOR_POINT_OUT(mon_out), .BRAKE_OUT(brake), .JOG_SPEED_OUT(jog_speed));
  dos_rx_model dos_rx_model_inst (.clk_in(clk), .clr_in(clr), .a_in(pa), .b_in(pb),
    .quad_pos(qpos), .rise_a(na), .rise_b(nb), .last_word(word));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] expd(input int c);
    return (c == 1) ? abs_pos : (c > 1 && c < 6) ? {16'h0, src[c-1]} : {16'h0, src[0]};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
  endtask
  // the slave is zero wait, but the master still waits on hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic pulses(input int k, input logic dir);
    repeat (k) begin
      @(posedge clk);
      step <= 1'b1;
      inc <= dir;
      @(posedge clk);
      step <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {hsel, hwrite, mon_sel, step, inc, en, alarm, jog, clr} = '0;
    htrans = 2'h0;
    hsize = dos_pkg::HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    spd = 10'h0;
    rnd = 32'hE70E;
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      src[i] = {1'b0, rnd[14:0]};
    end
    abs_pos = lfsr(rnd);
    nrst = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ra_tab[i], 32'h0);
      chk("reset value", rd, rv_tab[i]);
    end
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("bus response", hresp, 1'b0);
    $display("test registers done");
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, dos_pkg::OFS_PULSE_TYPE, t);
      repeat (4) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      rnd = lfsr(rnd);
      ni = 1 + rnd[2:0];
      nd = rnd[5:3];
      pulses(ni, 1'b1);
      pulses(nd, 1'b0);
      repeat (4) @(posedge clk);
      if (t == 1 || t == 3)
        chk("quad steps", qpos, (t == 1) ? ni - nd : nd - ni);
      else begin
        chk("pulses a", na, (t == 0) ? ni : nd);
        chk("pulses b", nb, (t == 0) ? nd : ni);
      end
    end
    $display("test pulse types done");
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 7; c++) begin
        n = (c + 3) % 6;
        bus(1'b1, dos_pkg::OFS_CODING, s ? {n[3:0], 4'(c), 8'h0} : {4'(c), n[3:0], 8'h0});
        mon_sel <= s[0];
        repeat (6) @(posedge clk);
        chk("display value", disp_value, expd(c));
        if (c < 6)
          chk("display select", disp_sel, c);
      end
    end
    $display("test display done");
    for (int f = 0; f < 16; f++) begin
      bus(1'b1, dos_pkg::OFS_MON_FUNC, f[2:0]);
      mon_sel <= f[3];
      repeat (6) @(posedge clk);
      mv = (f[3] ? f[2] : f[1]) ? src[6] : src[5];
      if (f[0])
        mv = 16'h0000 - mv;
      chk("monitor", mon_out, mv);
    end
    $display("test monitor done");
    bus(1'b1, dos_pkg::OFS_BRAKE_TH, 32'h7D0);
    bus(1'b0, dos_pkg::OFS_BRAKE_TH, 32'h0);
    chk("threshold limit", rd, 32'h3E8);
    bus(1'b1, dos_pkg::OFS_BRAKE_TH, 32'h1F4);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, dos_pkg::OFS_BRAKE_MODE, m);
      spd <= 10'h258;
      en <= 1'b1;
      repeat (6) @(posedge clk);
      chk("brake enabled", brake, 1'b0);
      en <= 1'b0;
      repeat (6) @(posedge clk);
      chk("brake fast", brake, 1'b0);
      spd <= 10'h190;
      repeat (6) @(posedge clk);
      chk("brake slow", brake, m != 0);
    end
    en <= 1'b1;
    alarm <= 1'b1;
    repeat (3) @(posedge clk);
    chk("brake alarm", brake, 1'b1);
    alarm <= 1'b0;
    jog <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, dos_pkg::OFS_TEST_SPEED, js_tab[i]);
      repeat (3) @(posedge clk);
      chk("jog speed", jog_speed, je_tab[i]);
    end
    jog <= 1'b0;
    repeat (3) @(posedge clk);
    chk("jog idle", jog_speed, 12'h0);
    $display("test brake and jog done");
    // absolute formats 0-3, then format 3 on the display feeds is ignored: 16 bits for function 1, 32 for function 2
    for (int g = 0; g < 6; g++) begin
      bus(1'b1, dos_pkg::OFS_CODING, (g >= 4) ? {12'h113, 4'(g - 3)} : {8'h0, 4'(g), 4'h3});
      repeat (400) @(posedge clk);
      n = (g == 1) ? 23 : (g == 2) ? 24 : 31;
      mk = (g == 4) ? 32'hFFFF : (32'h1 << (n + 1)) - 1;
      ex = (g == 0 || g == 5) ? abs_pos : (g == 4) ? {16'h0, abs_pos[15:0]} :
           (((abs_pos & (mk >> 1)) << 1) | ^(abs_pos & (mk >> 1)));
      chk("serial word", word & mk, ex);
    end
    $display("test serial done");
    complete_run();
  end
endmodule
`default_nettype wire
